// [rtl/psoc_map.vh]
// Register map, field positions, reset values and timing constants
// for the supply-on control block; included by every design file.
`ifndef PSOC_MAP_VH
`define PSOC_MAP_VH

// Register index of the control register and its byte address
`define PSOC_CTRL_INDEX 8'h2d
`define PSOC_CTRL_ADDR (`PSOC_CTRL_INDEX * 4)
`define PSOC_ADDR_W 8

// Field positions
`define PSOC_BIT_IND_POL 7
`define PSOC_BIT_LAST_ON 6
`define PSOC_BIT_ON_POL 5
`define PSOC_BIT_CROW_HI 4
`define PSOC_BIT_CROW_LO 3
`define PSOC_BIT_RESUME 2
`define PSOC_BIT_OFF 1
`define PSOC_BIT_MODE 0

// Reset values
`define PSOC_RST_IND_POL 1'b0
`define PSOC_RST_LAST_ON 1'b0
`define PSOC_RST_CROW 2'b11
`define PSOC_RST_RESUME 1'b0
`define PSOC_RST_MODE 1'b0
`define PSOC_MODE_LEGACY 1'b0
`define PSOC_MODE_ACPI 1'b1

// Crowbar timeouts (typical figures, milliseconds) and clock rate
`define PSOC_CLK_KHZ 40000
`define PSOC_CROW0_MS 600
`define PSOC_CROW1_MS 1100
`define PSOC_CROW2_MS 1600
`define PSOC_CROW3_MS 2100
`define PSOC_CROW0_CYC (`PSOC_CROW0_MS * `PSOC_CLK_KHZ)
`define PSOC_CROW1_CYC (`PSOC_CROW1_MS * `PSOC_CLK_KHZ)
`define PSOC_CROW2_CYC (`PSOC_CROW2_MS * `PSOC_CLK_KHZ)
`define PSOC_CROW3_CYC (`PSOC_CROW3_MS * `PSOC_CLK_KHZ)
`define PSOC_CROW_W 27

// AXI responses
`define PSOC_RESP_OKAY 2'b00
`define PSOC_RESP_SLVERR 2'b10

`endif

// [rtl/psoc_crowbar.v]
// Crowbar timer: measures how long the power button is held and
// fires a one-cycle pulse when the selected timeout is reached.
// Assumes the button input is already synchronous to aclk.
`timescale 1ns/1ps
`include "psoc_map.vh"

module psoc_crowbar #(
    parameter [`PSOC_CROW_W-1:0] T0_CYC = `PSOC_CROW0_CYC,
    parameter [`PSOC_CROW_W-1:0] T1_CYC = `PSOC_CROW1_CYC,
    parameter [`PSOC_CROW_W-1:0] T2_CYC = `PSOC_CROW2_CYC,
    parameter [`PSOC_CROW_W-1:0] T3_CYC = `PSOC_CROW3_CYC
) (
    input wire aclk,
    input wire aresetn,
    input wire button_held,
    input wire [1:0] timeout_sel,
    output reg expired
);
    reg [`PSOC_CROW_W-1:0] count;
    reg [`PSOC_CROW_W-1:0] limit;
    reg fired;

    // Each setting is an exact count, so the settings sit well apart
    always @* begin
        case (timeout_sel)
            2'b00: limit = T0_CYC;
            2'b01: limit = T1_CYC;
            2'b10: limit = T2_CYC;
            default: limit = T3_CYC;
        endcase
    end

    // Count while held; fire once per press, not repeatedly
    always @(posedge aclk) begin
        if (!aresetn) begin
            count <= {`PSOC_CROW_W{1'b0}};
            fired <= 1'b0;
            expired <= 1'b0;
        end else if (!button_held) begin
            count <= {`PSOC_CROW_W{1'b0}};
            fired <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (!fired) begin
                if (count + 1'b1 >= limit) begin
                    expired <= 1'b1;
                    fired <= 1'b1;
                end
                count <= count + 1'b1;
            end
        end
    end
endmodule

// [rtl/psoc_axil.v]
// AXI4-Lite slave front end for the supply-on control block.
// Hands one write pulse to the register file and samples its read value with no strobe.
// Assumes a single master that obeys the AXI4-Lite handshakes.
`timescale 1ns/1ps
`include "psoc_map.vh"

module psoc_axil (
    input wire aclk,
    input wire aresetn,
    input wire [`PSOC_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`PSOC_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire reg_wr,
    output wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata
);
    reg [`PSOC_ADDR_W-1:0] aw_addr;
    reg aw_full;
    reg [7:0] w_data;
    reg w_lane0;
    reg w_full;
    wire do_write;

    // One decoder serves both the write and the read path
    function addr_hit;
        input [`PSOC_ADDR_W-1:0] addr;
        begin
            addr_hit = (addr[`PSOC_ADDR_W-1:2] ==
                        `PSOC_CTRL_ADDR >> 2);
        end
    endfunction

    // Hold new addresses off while a response is still pending
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_full && w_full && !s_axi_bvalid;
    // Only byte lane 0 carries the 8-bit register
    assign reg_wr = do_write && w_lane0 && addr_hit(aw_addr);
    assign reg_wdata = w_data;

    // Write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= {`PSOC_ADDR_W{1'b0}};
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PSOC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_hit(aw_addr) ? `PSOC_RESP_OKAY :
                               `PSOC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: data registered one cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PSOC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (addr_hit(s_axi_araddr)) begin
                s_axi_rdata <= {24'h00_0000, reg_rdata};
                s_axi_rresp <= `PSOC_RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `PSOC_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// [rtl/psoc_ctrl.v]
// Supply-on and power-button control register with its supply logic.
// Assumes aresetn models the battery power-up reset and that the
// standby power-up, standby failure and power-return events arrive
// as one-cycle pulses synchronous to aclk.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "psoc_map.vh"

module psoc_ctrl #(
    parameter [`PSOC_CROW_W-1:0] CROW0_CYC = `PSOC_CROW0_CYC,
    parameter [`PSOC_CROW_W-1:0] CROW1_CYC = `PSOC_CROW1_CYC,
    parameter [`PSOC_CROW_W-1:0] CROW2_CYC = `PSOC_CROW2_CYC,
    parameter [`PSOC_CROW_W-1:0] CROW3_CYC = `PSOC_CROW3_CYC
) (
    input wire aclk,
    input wire aresetn,
    input wire [`PSOC_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`PSOC_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire standby_por,
    input wire standby_fail,
    input wire power_return,
    input wire supply_on_polarity_strap,
    input wire chipset_sleep_state_input,
    input wire power_button,
    input wire [1:0] indicator_lit,
    output reg supply_on_output,
    output reg [1:0] indicator_out
);
    // Supply sequencer states
    localparam [2:0] ST_FOLLOW = 3'b001;
    localparam [2:0] ST_HELD = 3'b010;
    localparam [2:0] ST_DOWN = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg supply_on;
    reg next_supply_on;

    // Register fields
    reg ind_pol;
    reg last_on;
    reg on_pol;
    reg [1:0] crow_sel;
    reg resume_last;
    reg button_mode;
    reg strap_pending;
    reg sleep_d;

    wire reg_wr;
    wire [7:0] reg_wdata;
    wire [7:0] reg_rdata;
    wire crow_expired;
    wire off_request;
    wire sleep_edge;
    wire legacy;

    psoc_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata)
    );

    // Button override only counts while the supply is actually on
    psoc_crowbar #(
        .T0_CYC(CROW0_CYC),
        .T1_CYC(CROW1_CYC),
        .T2_CYC(CROW2_CYC),
        .T3_CYC(CROW3_CYC)
    ) u_crowbar (
        .aclk(aclk),
        .aresetn(aresetn),
        .button_held(power_button && supply_on),
        .timeout_sel(crow_sel),
        .expired(crow_expired)
    );

    assign legacy = (button_mode == `PSOC_MODE_LEGACY);
    // Shut-off exists only in legacy mode; in ACPI mode it is ignored
    assign off_request = reg_wr && reg_wdata[`PSOC_BIT_OFF] &&
                         legacy;
    assign sleep_edge = chipset_sleep_state_input ^ sleep_d;

    // Read view: bit 1 always 0; bit 6 only meaningful in legacy mode
    assign reg_rdata = {ind_pol,
                        legacy & last_on,
                        on_pol,
                        crow_sel,
                        resume_last,
                        1'b0,
                        button_mode};

    // Battery-owned fields: only the battery reset touches them, so
    // they survive standby loss
    always @(posedge aclk) begin
        if (!aresetn) begin
            crow_sel <= `PSOC_RST_CROW;
            resume_last <= `PSOC_RST_RESUME;
        end else if (reg_wr) begin
            crow_sel <= reg_wdata[`PSOC_BIT_CROW_HI:`PSOC_BIT_CROW_LO];
            resume_last <= reg_wdata[`PSOC_BIT_RESUME];
        end
    end

    // Standby-owned fields: cleared by battery or standby power-up
    always @(posedge aclk) begin
        if (!aresetn || standby_por) begin
            ind_pol <= `PSOC_RST_IND_POL;
            button_mode <= `PSOC_RST_MODE;
        end else if (reg_wr) begin
            ind_pol <= reg_wdata[`PSOC_BIT_IND_POL];
            button_mode <= reg_wdata[`PSOC_BIT_MODE];
        end
    end

    // Polarity strap is caught one cycle after a power-up, never
    // inside the reset branch itself
    always @(posedge aclk) begin
        if (!aresetn) begin
            strap_pending <= 1'b1;
            on_pol <= 1'b0;
        end else if (standby_por) begin
            strap_pending <= 1'b1;
        end else if (strap_pending) begin
            strap_pending <= 1'b0;
            on_pol <= supply_on_polarity_strap;
        end
    end

    // Supply state caught at each standby failure, polarity-free
    always @(posedge aclk) begin
        if (!aresetn) begin
            last_on <= `PSOC_RST_LAST_ON;
        end else if (standby_fail) begin
            last_on <= supply_on;
        end
    end

    // Edge detector on the sleep-state input; it tracks the pin through
    // reset too, so no false edge follows the release
    always @(posedge aclk) begin
        sleep_d <= chipset_sleep_state_input;
    end

    // Supply sequencer. FOLLOW tracks the sleep-state input, HELD keeps
    // a restored state until the chipset moves, DOWN keeps a forced
    // shut-off until the chipset moves.
    always @* begin
        next_state = state;
        next_supply_on = supply_on;
        case (state)
            ST_FOLLOW: begin
                next_supply_on = chipset_sleep_state_input;
            end
            ST_HELD: begin
                if (sleep_edge) begin
                    next_state = ST_FOLLOW;
                    next_supply_on = chipset_sleep_state_input;
                end
            end
            ST_DOWN: begin
                next_supply_on = 1'b0;
                if (sleep_edge) begin
                    next_state = ST_FOLLOW;
                    next_supply_on = chipset_sleep_state_input;
                end
            end
            default: begin
                next_state = ST_FOLLOW;
                next_supply_on = 1'b0;
            end
        endcase
        // Power return outranks the chipset; forced off outranks both, and a standby failure outranks it
        if (power_return) begin
            if (resume_last) begin
                next_state = ST_HELD;
                next_supply_on = last_on;
            end else begin
                next_state = ST_FOLLOW;
                next_supply_on = chipset_sleep_state_input;
            end
        end
        if (off_request || crow_expired) begin
            next_state = ST_DOWN;
            next_supply_on = 1'b0;
        end
    end

    // Sequencer registers; a standby failure drops the supply
    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_FOLLOW;
            supply_on <= 1'b0;
        end else if (standby_fail) begin
            state <= ST_FOLLOW;
            supply_on <= 1'b0;
        end else begin
            state <= next_state;
            supply_on <= next_supply_on;
        end
    end

    // Pin drivers: supply pin is active high when the strap bit is 1;
    // registered so the pins never glitch on a register write
    always @(posedge aclk) begin
        if (!aresetn) begin
            supply_on_output <= 1'b1;
            indicator_out <= 2'b00;
        end else begin
            supply_on_output <= on_pol ? supply_on : ~supply_on;
            indicator_out <= ind_pol ? ~indicator_lit :
                             indicator_lit;
        end
    end
endmodule

// [verification/psoc_far_model.sv]
// Far-side model: the chipset sleep-state signal and the supply itself.
// Assumes the bench asks for supply changes through sleep_want.
`timescale 1ns/1ps

module psoc_far_model (
    input wire aclk,
    input wire power_lost,
    input wire sleep_want,
    input wire supply_on_output,
    input wire supply_on_polarity_strap,
    output reg chipset_sleep_state_input = 1'b0,
    output wire supply_is_on
);
    reg want_q = 1'b0;

    // After any power loss the chipset comes back asking for off; only a
    // fresh request turns it on again, so a resumed state is not undone
    always @(posedge aclk) begin
        want_q <= sleep_want;
        if (power_lost) begin
            chipset_sleep_state_input <= 1'b0;
        end else if (sleep_want != want_q) begin
            chipset_sleep_state_input <= sleep_want;
        end
    end

    // The supply reads the pin through the strap polarity
    assign supply_is_on = (supply_on_output == supply_on_polarity_strap);
endmodule

// [verification/psoc_ctrl_assertions.sv]
// Port checks on the supply-on control block: bus handshakes, read
// answers and the supply and indicator pins.
// Assumes one clock and the synchronous active-low battery reset.
`timescale 1ns/1ps
`include "psoc_map.vh"

module psoc_ctrl_assertions (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`PSOC_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire standby_fail,
    input wire supply_on_polarity_strap,
    input wire [1:0] indicator_lit,
    input wire supply_on_output,
    input wire [1:0] indicator_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before it was taken");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    chk_write_busy: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
    chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr[7:2] != 6'h2d |=> s_axi_rdata == 32'h0000_0000 &&
        s_axi_rresp == `PSOC_RESP_SLVERR) else $error("unmapped read answer");
    chk_reg_read: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr[7:2] == 6'h2d |=> s_axi_rdata[31:8] == 24'h00_0000 &&
        !s_axi_rdata[1] && s_axi_rresp == `PSOC_RESP_OKAY)
        else $error("register read answer wrong");
    chk_fail_off: assert property (standby_fail |-> ##[1:3]
        supply_on_output != supply_on_polarity_strap)
        else $error("supply not off after standby failure");
    chk_ind_polar: assert property ($past(aresetn) |->
        (indicator_out ^ $past(indicator_lit)) inside {2'b00, 2'b11})
        else $error("indicator bits disagree on polarity");
endmodule

bind psoc_ctrl psoc_ctrl_assertions chk_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .standby_fail(standby_fail),
    .supply_on_polarity_strap(supply_on_polarity_strap),
    .indicator_lit(indicator_lit), .supply_on_output(supply_on_output),
    .indicator_out(indicator_out)
);

// [verification/testbench.sv]
// Self-checking bench for the supply-on control block over AXI4-Lite.
// Assumes the far-side model and short crowbar counts for simulation.
`timescale 1ns/1ps
`include "psoc_map.vh"

module testbench;
    localparam logic [7:0] REG_A = 8'(`PSOC_CTRL_ADDR);
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr, d;
    logic [31:0] wdata, rd;
    logic [3:0] wstrb;
    logic [2:0] ev;
    logic [1:0] indicator_lit, rsp;
    logic strap, sleep_want, power_button;
    wire awready, wready, bvalid, arready, rvalid, supply, sleep, is_on;
    wire [1:0] bresp, rresp, indicator_out;
    wire [31:0] rdata;
    int fails, n_tests;

    psoc_ctrl #(.CROW0_CYC(27'h000a), .CROW1_CYC(27'h0014),
        .CROW2_CYC(27'h001e), .CROW3_CYC(27'h0028)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .standby_por(ev[0]), .standby_fail(ev[1]),
        .power_return(ev[2]), .supply_on_polarity_strap(strap),
        .chipset_sleep_state_input(sleep), .power_button(power_button),
        .indicator_lit(indicator_lit), .supply_on_output(supply),
        .indicator_out(indicator_out));

    psoc_far_model far_u (.aclk(aclk), .power_lost(ev[1]),
        .sleep_want(sleep_want), .supply_on_output(supply),
        .supply_on_polarity_strap(strap),
        .chipset_sleep_state_input(sleep), .supply_is_on(is_on));

    // Clock at 40 MHz
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
        input logic [3:0] s, output logic [1:0] r);
        logic aw, w;
        int n;
        aw = 1'b1;
        w = 1'b1;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while ((aw || w) && n < 100) begin
            @(posedge aclk);
            n++;
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        // A late bready now and then lets the hold checks see a stall
        repeat ($urandom % 3) @(posedge aclk);
        bready <= 1'b1;
        do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 100);
        if (n >= 100) fails++;
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 100);
        arvalid <= 1'b0;
        repeat ($urandom % 3) @(posedge aclk);
        rready <= 1'b1;
        do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 100);
        if (n >= 100) fails++;
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic reg_write(input logic [7:0] v);
        axi_write(REG_A, {24'h00_0000, v}, 4'hf, rsp);
        chk("bresp", `PSOC_RESP_OKAY, rsp);
        repeat (3) @(posedge aclk);
    endtask

    task automatic reg_check(input logic [7:0] exp);
        axi_read(REG_A, rd, rsp);
        chk("register", {24'h00_0000, exp}, rd);
        chk("rresp", `PSOC_RESP_OKAY, rsp);
    endtask

    // One-cycle event pulse, then time for the supply logic to settle
    task automatic pulse(input int i);
        @(posedge aclk);
        ev[i] <= 1'b1;
        @(posedge aclk);
        ev[i] <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    // A fresh on request from the chipset
    task automatic cycle_sleep;
        sleep_want <= 1'b0;
        repeat (3) @(posedge aclk);
        sleep_want <= 1'b1;
        repeat (4) @(posedge aclk);
    endtask

    // Register image from what was written; bit 6 hides in ACPI mode
    function automatic logic [7:0] exp_reg(input logic [7:0] w,
        input logic last_on);
        return {w[7], last_on & ~w[0], strap, w[4:3], w[2], 1'b0, w[0]};
    endfunction

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        complete_run();
    end

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {ev, indicator_lit, power_button} = 6'h0;
        strap = 1'b1;
        sleep_want = 1'b1;
        void'($urandom(32'he3cb));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        reg_check(8'h38);
        // Corner values first, then random ones
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            indicator_lit <= 2'($urandom);
            reg_write(d);
            reg_check(exp_reg(d, 1'b0));
            chk("indicator", {2{d[7]}} ^ indicator_lit, indicator_out);
        end
        reg_write(8'h00);
        cycle_sleep();
        chk("supply", 1, is_on);
        reg_write(8'h02);
        chk("supply", 0, is_on);
        reg_check(exp_reg(8'h02, 1'b0));
        cycle_sleep();
        // The off bit obeys the mode in force before the write lands
        reg_write(8'h01);
        reg_write(8'h03);
        chk("supply", 1, is_on);
        reg_write(8'h04);
        pulse(1);
        chk("supply", 0, is_on);
        reg_check(exp_reg(8'h04, 1'b1));
        pulse(2);
        chk("supply", 1, is_on);
        reg_write(8'h00);
        pulse(1);
        pulse(2);
        chk("supply", 0, is_on);
        reg_write(8'h9d);
        pulse(0);
        reg_check(exp_reg(8'h1c, 1'b1));
        // Crowbar: shortest setting fires, next one not yet
        reg_write(8'h00);
        cycle_sleep();
        power_button <= 1'b1;
        repeat (15) @(posedge aclk);
        chk("supply", 0, is_on);
        power_button <= 1'b0;
        cycle_sleep();
        reg_write(8'h08);
        power_button <= 1'b1;
        repeat (15) @(posedge aclk);
        chk("supply", 1, is_on);
        repeat (10) @(posedge aclk);
        chk("supply", 0, is_on);
        power_button <= 1'b0;
        // Unmapped place and a write with lane 0 disabled
        axi_write(8'h10, 32'h0000_00ff, 4'hf, rsp);
        chk("bresp", `PSOC_RESP_SLVERR, rsp);
        axi_read(8'h10, rd, rsp);
        chk("rdata", 0, rd);
        chk("rresp", `PSOC_RESP_SLVERR, rsp);
        axi_write(REG_A, 32'h0000_0080, 4'h0, rsp);
        reg_check(exp_reg(8'h08, 1'b1));
        // Battery reset in mid-run
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        reg_check(8'h38);
        complete_run();
    end
endmodule
